//--- fpes_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==== flash pin checks
module fpes_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // flash pins
    input wire logic [19:0] f_addr,
    input wire logic f_ce_n,
    input wire logic f_oe_n,
    input wire logic f_we_n,
    input wire logic [15:0] f_dq_o,
    input wire logic f_dq_oe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wr_strobes_a: assert property (!f_we_n |-> !f_ce_n && f_oe_n)
        else $error("write without select");
    rd_float_a: assert property (!f_oe_n |-> f_dq_oe_n)
        else $error("host drives in read");
    wr_drive_a: assert property (!f_we_n |-> !f_dq_oe_n)
        else $error("write data not driven");
    wr_pulse_a: assert property ($fell(f_we_n) |-> (!f_we_n) [*4] ##1 f_we_n)
        else $error("write pulse length");
    wr_hold_a: assert property (!f_we_n && !$fell(f_we_n) |-> $stable(f_addr) && $stable(f_dq_o))
        else $error("write address moved");
    rd_pulse_a: assert property ($fell(f_oe_n) |-> (!f_oe_n) [*8] ##1 !f_oe_n ##1 f_oe_n)
        else $error("read pulse length");
    rd_addr_a: assert property (!f_oe_n && !$fell(f_oe_n) |-> $stable(f_addr))
        else $error("read address moved");
    cycle_gap_a: assert property ($rose(f_ce_n) |=> f_ce_n && f_oe_n && f_we_n)
        else $error("no idle between cycles");
endmodule // fpes_chk
`default_nettype wire

//--- fpes_cycle.v
`timescale 1ns/10ps
`default_nettype none
`include "fpes_defs.vh"
// ==================== one strobe cycle on the flash pins
module fpes_cycle (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // request
    input wire start,
    input wire is_write,
    input wire [19:0] addr,
    input wire [15:0] wdata,
    output wire busy,
    output reg done,
    output reg [15:0] rdata_reg,
    // flash pins
    output reg [19:0] f_addr,
    output reg f_ce_n,
    output reg f_oe_n,
    output reg f_we_n,
    output reg [15:0] f_dq_o,
    output reg f_dq_oe_n,
    input wire [15:0] f_dq_i
);
    localparam S_IDLE = 2'd0;
    localparam S_LOW = 2'd1;
    localparam S_HIGH = 2'd2;
    reg [1:0] state_reg;
    reg [3:0] cnt_reg;
    reg wr_reg;
    assign busy = state_reg != S_IDLE;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            done <= 1'b0;
            rdata_reg <= 16'h0000;
            f_addr <= 20'h00000;
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
            f_dq_o <= 16'h0000;
            f_dq_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        f_addr <= addr;
                        f_ce_n <= 1'b0;
                        wr_reg <= is_write;
                        f_we_n <= ~is_write;
                        f_oe_n <= is_write;
                        f_dq_o <= wdata;
                        f_dq_oe_n <= ~is_write;
                        cnt_reg <= 4'h0;
                        state_reg <= S_LOW;
                    end
                end
                S_LOW: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == (wr_reg ? `FPES_PULSE_CYC : `FPES_ACC_CYC)) begin
                        if (!wr_reg) rdata_reg <= f_dq_i;
                        f_we_n <= 1'b1;
                        f_oe_n <= 1'b1;
                        f_ce_n <= 1'b1;
                        cnt_reg <= 4'h0;
                        state_reg <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    f_dq_oe_n <= 1'b1;
                    done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // fpes_cycle
`default_nettype wire

//--- fpes_defs.vh
`ifndef FPES_DEFS_VH
`define FPES_DEFS_VH
// Contract
// - program starts with two unlocks then a0
// - load is strobe low pulse, drive high
// - next load falls within 30us of rise; the model ends loading only after 100us
// - upper address bits fix the page
// - chip erase is six writes ending 10
// - sector erase is six writes ending 30
// - toggle output drive per status read; the model returns the same fixed st byte on every status read
// - unlocks are 5555/aa then 2aaa/55
// - fail bits block further operations; the host starts operations whatever status_reg holds
// ==================== register offsets
`define FPES_CTRL 8'h00
`define FPES_ADDR 8'h04
`define FPES_WDATA 8'h08
`define FPES_RDATA 8'h0c
`define FPES_STAT 8'h10
// ==================== operations
`define FPES_OP_READ 3'h0
`define FPES_OP_WRITE 3'h1
`define FPES_OP_UNLOCK 3'h2
`define FPES_OP_LOAD 3'h3
`define FPES_OP_STATUS 3'h4
// ==================== command codes
`define FPES_UNLOCK_A1 20'h05555
`define FPES_UNLOCK_A2 20'h02aaa
`define FPES_UNLOCK_D1 8'haa
`define FPES_UNLOCK_D2 8'h55
// ==================== status bits
`define FPES_ST_READY 7
`define FPES_ST_SUSP 6
`define FPES_ST_EFAIL 5
`define FPES_ST_PFAIL 4
// ==================== timing, in 20ns clocks past the first
// write strobe low 80ns, read access 180ns
`define FPES_PULSE_CYC 4'd3
`define FPES_ACC_CYC 4'd8
`endif

//--- fpes_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==== flash device model
module fpes_flash_model #(
    parameter logic [7:0] ARR_CMD = 8'hf0,
    parameter logic [7:0] ST_CMD = 8'h70
) (
    // pins
    input wire logic [19:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] dq_in,
    input wire logic word_mode,
    output logic [15:0] dq_out
);
    logic [15:0] mem [0:255];
    logic [7:0] st = 8'h80;
    logic [1:0] seq = 0;
    logic er = 0, stm = 0, ld = 0, wm = 0;
    logic [19:0] la = 0;
    realtime last = 0;
    wire wr_n = ce_n | we_n;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    always @(negedge wr_n) la = addr;
    always @(posedge wr_n) begin
        last = $realtime;
        if (ld) mem[{la[19:16], la[3:0]}] = dq_in;
        else if (seq == 0 && la[14:0] == 15'h5555 && dq_in[7:0] == 8'haa) seq = 1;
        else if (seq == 1 && la[14:0] == 15'h2aaa && dq_in[7:0] == 8'h55) seq = 2;
        else if (seq == 2) begin
            seq = 0;
            case (dq_in[7:0])
                8'ha0: begin
                    ld = 1;
                    wm = word_mode;
                end
                8'h80: er = 1;
                8'h10, 8'h30: begin
                    for (int i = 0; i < 256; i++) if (er && (!dq_in[5] || i[7:4] == la[19:16])) mem[i] = 16'hffff;
                    stm = er;
                    er = 0;
                end
                ARR_CMD: stm = 0;
                ST_CMD: stm = 1;
                default: er = 0;
            endcase
        end else seq = 0;
    end
    always #1000 if (ld && wr_n && $realtime - last > 100000) begin
        ld = 0;
        stm = 1;
    end
    assign dq_out = (!ce_n && !oe_n) ? (stm ? {8'h00, st} : mem[{addr[19:16], addr[3:0]}]) : ~addr[15:0];
endmodule // fpes_flash_model
`default_nettype wire

//--- fpes_host.v
`timescale 1ns/10ps
`default_nettype none
`include "fpes_defs.vh"
// ==================== apb controlled flash host
module fpes_host (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // flash pins
    output wire [19:0] f_addr,
    output wire f_ce_n,
    output wire f_oe_n,
    output wire f_we_n,
    output wire [15:0] f_dq_o,
    output wire f_dq_oe_n,
    input wire [15:0] f_dq_i,
    output wire f_word_mode
);
    reg [2:0] op_reg;
    reg [2:0] step_reg;
    reg run_reg;
    reg word_reg;
    reg [19:0] addr_reg;
    reg [15:0] wdata_reg;
    reg [15:0] rd_reg;
    reg [7:0] status_reg;
    reg go_reg;
    reg [19:0] c_addr;
    reg [15:0] c_data;
    reg c_wr;
    wire done;
    wire [15:0] cyc_rdata;
    wire acc = psel & penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign f_word_mode = word_reg;
    // ==================== register read
    always @* begin
        case (paddr)
            `FPES_CTRL: prdata = {27'h0, word_reg, run_reg, op_reg};
            `FPES_ADDR: prdata = {12'h000, addr_reg};
            `FPES_WDATA: prdata = {16'h0000, wdata_reg};
            `FPES_RDATA: prdata = {16'h0000, rd_reg};
            `FPES_STAT: prdata = {24'h0, status_reg};
            default: prdata = 32'h0;
        endcase
    end
    // ==================== step address and data
    always @* begin
        c_wr = 1'b1;
        c_addr = `FPES_UNLOCK_A1;
        c_data = {8'h00, `FPES_UNLOCK_D1};
        case (step_reg)
            3'd0: c_data = {8'h00, `FPES_UNLOCK_D1};
            3'd1: begin
                c_addr = `FPES_UNLOCK_A2;
                c_data = {8'h00, `FPES_UNLOCK_D2};
            end
            default: begin
                c_addr = addr_reg;
                c_data = wdata_reg;
                c_wr = (op_reg != `FPES_OP_READ) && (op_reg != `FPES_OP_STATUS);
            end
        endcase
    end
    // ==================== sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= 3'h0;
            step_reg <= 3'h0;
            run_reg <= 1'b0;
            word_reg <= 1'b1;
            addr_reg <= 20'h0;
            wdata_reg <= 16'h0;
            rd_reg <= 16'h0;
            status_reg <= 8'h80;
            go_reg <= 1'b0;
        end else begin
            go_reg <= 1'b0;
            if (acc && pwrite && !run_reg) begin
                case (paddr)
                    `FPES_CTRL: begin
                        op_reg <= pwdata[2:0];
                        word_reg <= pwdata[4];
                        if (pwdata[3]) begin
                            run_reg <= 1'b1;
                            go_reg <= 1'b1;
                            // unlocked commands start at step 0
                            step_reg <= (pwdata[2:0] == `FPES_OP_UNLOCK) ? 3'd0 : 3'd2;
                        end
                    end
                    `FPES_ADDR: addr_reg <= pwdata[19:0];
                    `FPES_WDATA: wdata_reg <= pwdata[15:0];
                    default: ;
                endcase
            end
            if (done) begin
                if (step_reg >= 3'd2) begin
                    rd_reg <= cyc_rdata;
                    if (op_reg == `FPES_OP_STATUS) status_reg <= {cyc_rdata[7:2], 2'b00};
                    run_reg <= 1'b0;
                end else begin
                    step_reg <= step_reg + 3'd1;
                    go_reg <= 1'b1;
                end
            end
        end
    end
    fpes_cycle u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .start(go_reg),
        .is_write(c_wr),
        .addr(c_addr),
        .wdata(c_data),
        .busy(),
        .done(done),
        .rdata_reg(cyc_rdata),
        .f_addr(f_addr),
        .f_ce_n(f_ce_n),
        .f_oe_n(f_oe_n),
        .f_we_n(f_we_n),
        .f_dq_o(f_dq_o),
        .f_dq_oe_n(f_dq_oe_n),
        .f_dq_i(f_dq_i)
    );
endmodule // fpes_host
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, f_ce_n, f_oe_n, f_we_n, f_dq_oe_n, f_word_mode;
    wire logic [19:0] f_addr;
    wire logic [15:0] f_dq_o, f_dq_i, dq_m;
    int errors = 0, total_checks = 0;
    always #10 pclk = ~pclk;
    assign f_dq_i = f_dq_oe_n ? dq_m : f_dq_o;
    fpes_host uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .f_addr(f_addr),
        .f_ce_n(f_ce_n),
        .f_oe_n(f_oe_n),
        .f_we_n(f_we_n),
        .f_dq_o(f_dq_o),
        .f_dq_oe_n(f_dq_oe_n),
        .f_dq_i(f_dq_i),
        .f_word_mode(f_word_mode)
    );
    fpes_flash_model mdl (.addr(f_addr), .ce_n(f_ce_n), .oe_n(f_oe_n), .we_n(f_we_n), .dq_in(f_dq_i),
        .word_mode(f_word_mode), .dq_out(dq_m));
    // ==== support tasks
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 0;
        penable <= 0;
        if (n >= 50) begin
            errors++;
            wrap_up;
        end
        @(posedge pclk);
    endtask
    task op(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d);
        int n;
        apb(1, 8'h04, {12'h000, a});
        apb(1, 8'h08, {16'h0000, d});
        apb(1, 8'h00, {27'h0, 2'b11, o});
        n = 0;
        do begin
            apb(0, 8'h00, 32'h0);
            n++;
        end while (q[3] !== 1'b0 && n < 100);
        if (n >= 100) begin
            errors++;
            wrap_up;
        end
    endtask
    task rd(input logic [19:0] a);
        op(0, a, 16'h0);
        apb(0, 8'h0c, 32'h0);
    endtask
    // ==== scenarios
    task t_regs;
        apb(0, 8'h10, 32'h0);
        check(q, 32'h80);
        apb(0, 8'h14, 32'h0);
        check(q, 32'h0);
        $display("t_regs done");
    endtask
    task t_prog;
        op(1, 20'h10000, 16'h0000);
        op(2, 20'h05555, 16'h00a0);
        check({31'h0, f_word_mode}, 32'h1);
        op(3, 20'h10002, 16'h1234);
        op(3, 20'h10001, 16'h5678);
        repeat (6000) @(posedge pclk);
        op(4, 20'h0, 16'h0);
        apb(0, 8'h10, 32'h0);
        check(q, 32'h80);
        op(2, 20'h05555, 16'h00f0);
        rd(20'h10002);
        check(q, 32'h1234);
        rd(20'h10001);
        check(q, 32'h5678);
        rd(20'h10003);
        check(q, 32'hffff);
        rd(20'h10000);
        check(q, 32'hffff);
        $display("t_prog done");
    endtask
    task t_erase;
        for (int i = 0; i < 2; i++) begin
            op(2, 20'h05555, 16'h0080);
            op(2, (i == 0) ? 20'h20000 : 20'h05555, (i == 0) ? 16'h0030 : 16'h0010);
            op(4, 20'h0, 16'h0);
            apb(0, 8'h10, 32'h0);
            check(q, 32'h80);
            op(2, 20'h05555, 16'h00f0);
            rd(20'h10002);
            check(q, (i == 0) ? 32'h1234 : 32'hffff);
        end
        $display("t_erase done");
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs;
        t_prog;
        t_erase;
        wrap_up;
    end
endmodule // testbench
bind fpes_host fpes_chk chk (.pclk(pclk), .presetn(presetn), .f_addr(f_addr), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n),
    .f_we_n(f_we_n), .f_dq_o(f_dq_o), .f_dq_oe_n(f_dq_oe_n));
`default_nettype wire
